//--- bench/absolute_encoder_gray_counter_tb_top.sv
// Self-checking bench for the two-port Gray encoder position block
`timescale 1ns/1ps
module absolute_encoder_gray_counter_tb_top;
  import aegc_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  aegc_bus_t bus_req = '0;
  logic [15:0] rdata;
  logic [11:0] port1_code, port2_code, pos1 = 12'h000, pos2 = 12'h000;
  logic [3:0] nbits1 = 4'd12;
  logic scan_tick = 1'b0, hw_fault = 1'b0, irq;
  logic l1, l2, u1, u2, d1, d2;
  logic [15:0] rv;
  integer seed = 32'h47962733;
  int mismatches = 0, checks_done = 0, cyc = 0, p, n;
  aegc_encoder_model enc1 (.core_clk(core_clk), .position(pos1), .nbits(nbits1),
    .code(port1_code));
  aegc_encoder_model enc2 (.core_clk(core_clk), .position(pos2), .nbits(4'd12),
    .code(port2_code));
  aegc_top DUT (.core_clk(core_clk), .rst(rst), .bus_req(bus_req), .rdata(rdata),
    .port1_code(port1_code), .port2_code(port2_code), .scan_tick(scan_tick),
    .hw_fault(hw_fault), .port1_lsb_indicator(l1), .port2_lsb_indicator(l2),
    .port1_up_indicator(u1), .port2_up_indicator(u2), .port1_down_indicator(d1),
    .port2_down_indicator(d2), .irq(irq));
  always #2.5 core_clk = ~core_clk;
  function automatic logic [15:0] bcd4(input int v);
    return {4'(v / 1000 % 10), 4'(v / 100 % 10), 4'(v / 10 % 10), 4'(v % 10)};
  endfunction : bcd4
  // Value as reported: masked to resolution, scaled to degrees in angle mode
  function automatic logic [15:0] exp_pv(input int pos, input int res, input int mode);
    int nb;
    int m;
    nb = 8 + 2 * res;
    m = pos % (1 << nb);
    if (mode == 1)
      m = (m * 360) >> nb;
    return bcd4(m);
  endfunction : exp_pv
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    bus_req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge core_clk);
    bus_req <= '0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge core_clk);
    bus_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 16'h0000};
    @(posedge core_clk);
    bus_req <= '0;
    #1 d = rdata;
  endtask : rd
  task automatic rchk(input string name, input logic [7:0] a, input logic [15:0] exp);
    rd(a, rv);
    chk(name, exp, rv);
  endtask : rchk
  task automatic scan();
    @(posedge core_clk);
    scan_tick <= 1'b1;
    @(posedge core_clk);
    scan_tick <= 1'b0;
  endtask : scan
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : summarize
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      mismatches++;
      summarize();
    end
  end
  initial
  begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    rchk("cfg1 reset", AEGC_CFG1, AEGC_CFG_RST);
    rchk("ctrl reset", AEGC_CTRL, 16'(AEGC_CTRL_RST));
    rchk("mask reset", AEGC_MASK, 16'h0000);
    rchk("error none", AEGC_ERR, 16'(AEGC_ERR_NONE));
    rchk("unmapped", 8'h10, 16'h0000);
    // Indicators: random steps both ways on both ports
    for (int i = 0; i < 12; i++)
    begin
      p = 10 + ($unsigned($random(seed)) % 4000);
      n = p + (i % 2 == 0 ? 1 + i % 3 : -1 - i % 3);
      @(posedge core_clk);
      pos1 <= 12'(p);
      pos2 <= 12'(p);
      @(posedge core_clk);
      pos1 <= 12'(n);
      pos2 <= 12'(n);
      @(posedge core_clk);
      #1 chk("up1", 16'(n > p), 16'(u1));
      chk("down1", 16'(n < p), 16'(d1));
      chk("up2", 16'(n > p), 16'(u2));
      chk("down2", 16'(n < p), 16'(d2));
      chk("lsb1", 16'(n[0] ^ n[1]), 16'(l1));
      chk("lsb2", 16'(n[0] ^ n[1]), 16'(l2));
      @(posedge core_clk);
      #1 chk("up1 idle", 16'h0000, 16'(u1 | d1));
    end
    // Every resolution and mode on port 1, port 2 stays 12 bit BCD
    for (int r = 0; r < 3; r++)
      for (int m = 0; m < 2; m++)
      begin
        p = $unsigned($random(seed)) % 4096;
        n = $unsigned($random(seed)) % 4096;
        wr(AEGC_CFG1, {8'(m), 8'(r)});
        nbits1 <= 4'(8 + 2 * r);
        pos1 <= 12'(p);
        pos2 <= 12'(n);
        scan();
        rchk("pv1 lo", AEGC_PV1_LO, exp_pv(p, r, m));
        rchk("pv1 hi", AEGC_PV1_HI, 16'h0000);
        rchk("pv2 lo", AEGC_PV2_LO, exp_pv(n, 2, 0));
        rchk("pv2 hi", AEGC_PV2_HI, 16'h0000);
      end
    wr(AEGC_CFG1, AEGC_CFG_RST);
    nbits1 <= 4'd12;
    pos1 <= 12'd1234;
    wr(AEGC_ORG1, 16'd1000);
    scan();
    rchk("pv1 origin", AEGC_PV1_LO, 16'h0234);
    wr(AEGC_PRE1, 16'd500);
    scan();
    rchk("pv1 preset", AEGC_PV1_LO, 16'h0500);
    wr(AEGC_CTRL, 16'h0030);
    scan();
    rchk("pv1 capture", AEGC_PV1_LO, 16'h0000);
    wr(AEGC_ORG1, 16'h0000);
    // Target compare, mask, global mask and clear on read
    wr(8'h80 | (8'd2 << 1), 16'd777);
    wr(AEGC_MASK, 16'h0001);
    wr(AEGC_CTRL, 16'h0001);
    pos1 <= 12'd777;
    repeat (4) @(posedge core_clk);
    #1 chk("irq hit", 16'h0001, 16'(irq));
    wr(AEGC_MASK, 16'h0000);
    #1 chk("irq masked", 16'h0000, 16'(irq));
    wr(AEGC_MASK, 16'h0001);
    wr(AEGC_CTRL, 16'h0011);
    #1 chk("irq gmask", 16'h0000, 16'(irq));
    wr(AEGC_CTRL, 16'h0001);
    #1 chk("irq unmask", 16'h0001, 16'(irq));
    rchk("status", AEGC_STAT, 16'h0001);
    #1 chk("irq cleared", 16'h0000, 16'(irq));
    rchk("status clr", AEGC_STAT, 16'h0000);
    // Range flags with compare running, then stopped
    wr(8'h80 | (8'd3 << 1), 16'd100);
    wr(8'h80 | (8'd3 << 1) | 8'h01, 16'd200);
    wr(AEGC_CTRL, 16'h0005);
    pos1 <= 12'd150;
    repeat (3) @(posedge core_clk);
    rchk("range flags", AEGC_FLG1, 16'h0108);
    wr(AEGC_CTRL, 16'h0010);
    rchk("range stop", AEGC_FLG1, 16'h0000);
    @(posedge core_clk);
    hw_fault <= 1'b1;
    repeat (2) @(posedge core_clk);
    rchk("error hw", AEGC_ERR, 16'(AEGC_ERR_HW));
    @(posedge core_clk);
    hw_fault <= 1'b0;
    wr(AEGC_CFG2, 16'h0003);
    repeat (2) @(posedge core_clk);
    rchk("error cfg", AEGC_ERR, 16'(AEGC_ERR_CFG));
    // Port 2: angle mode, preset, range compare, interrupt and capture
    wr(AEGC_CFG2, 16'h0102);
    wr(AEGC_PRE2, 16'd3000);
    scan();
    rchk("pv2 angle", AEGC_PV2_LO, exp_pv(3000, 2, 1));
    rchk("error clear", AEGC_ERR, 16'(AEGC_ERR_NONE));
    wr(8'ha0 | (8'd5 << 1), 16'd200);
    wr(8'ha1 | (8'd5 << 1), 16'd300);
    wr(AEGC_MASK, 16'h0002);
    wr(AEGC_CTRL, 16'h000a);
    repeat (3) @(posedge core_clk);
    #1 chk("irq port2", 16'h0001, 16'(irq));
    rchk("range flags2", AEGC_FLG2, 16'h0120);
    rchk("status2", AEGC_STAT, 16'h0002);
    #1 chk("irq2 cleared", 16'h0000, 16'(irq));
    wr(AEGC_CTRL, 16'h0050);
    scan();
    rchk("pv2 capture", AEGC_PV2_LO, 16'h0000);
    summarize();
  end
endmodule : absolute_encoder_gray_counter_tb_top

//--- bench/aegc_encoder_model.sv
// Behavioural absolute encoder with a parallel Gray-coded output word
`timescale 1ns/1ps
module aegc_encoder_model (
  // Clock
  input wire logic core_clk,
  // Shaft position and encoder resolution
  input wire logic [11:0] position,
  input wire logic [3:0] nbits,
  // Parallel Gray output
  output logic [11:0] code
);
  logic junk_q = 1'b0;
  logic [11:0] live_mask;
  logic [11:0] pos_cut;
  // Unwired lines above the resolution toggle, so a leak into the value shows
  always @(posedge core_clk)
    junk_q <= ~junk_q;
  assign live_mask = 12'((13'h1 << nbits) - 13'h1);
  assign pos_cut = position & live_mask;
  // One line changes per step, so a skewed sample is off by one step only
  assign code = (pos_cut ^ (pos_cut >> 1)) | (~live_mask & {12{junk_q}});
  // Steps come at most once per clock, far inside the counting rate
endmodule : aegc_encoder_model

//--- shared/aegc_pkg.sv
// Package for the two-port absolute Gray encoder position block
package aegc_pkg;
  localparam int AEGC_GW = 12;
  localparam int AEGC_NCMP = 8;
  // Register addresses on the plain register port
  localparam logic [7:0] AEGC_PV1_LO = 8'he8;
  localparam logic [7:0] AEGC_PV1_HI = 8'he9;
  localparam logic [7:0] AEGC_PV2_LO = 8'hea;
  localparam logic [7:0] AEGC_PV2_HI = 8'heb;
  localparam logic [7:0] AEGC_CFG1 = 8'hd0;
  localparam logic [7:0] AEGC_CFG2 = 8'hd1;
  localparam logic [7:0] AEGC_ORG1 = 8'hd2;
  localparam logic [7:0] AEGC_ORG2 = 8'hd3;
  localparam logic [7:0] AEGC_PRE1 = 8'hd4;
  localparam logic [7:0] AEGC_PRE2 = 8'hd5;
  localparam logic [7:0] AEGC_CTRL = 8'hd6;
  localparam logic [7:0] AEGC_STAT = 8'hd7;
  localparam logic [7:0] AEGC_MASK = 8'hd8;
  localparam logic [7:0] AEGC_FLG1 = 8'hd9;
  localparam logic [7:0] AEGC_FLG2 = 8'hda;
  localparam logic [7:0] AEGC_ERR = 8'hdb;
  // Table space: 8'b10p0_iiih, p port, i entry, h high bound
  localparam logic [1:0] AEGC_TBL_TOP = 2'b10;
  // Control register fields
  localparam int AEGC_C_CMP_EN = 0;
  localparam int AEGC_C_RANGE = 2;
  localparam int AEGC_C_GMASK = 4;
  localparam int AEGC_C_CAPT = 5;
  localparam int AEGC_F_CMPING = 8;
  // Reset values
  localparam logic [15:0] AEGC_CFG_RST = 16'h0002;
  localparam logic [11:0] AEGC_ORG_RST = 12'h000;
  localparam logic [4:0] AEGC_CTRL_RST = 5'h10;
  localparam logic [1:0] AEGC_MASK_RST = 2'h0;
  // Error codes
  localparam logic [7:0] AEGC_ERR_NONE = 8'h00;
  localparam logic [7:0] AEGC_ERR_HW = 8'h01;
  localparam logic [7:0] AEGC_ERR_CFG = 8'h03;

  typedef enum logic [7:0] {
    AEGC_RES8 = 8'h00,
    AEGC_RES10 = 8'h01,
    AEGC_RES12 = 8'h02
  } aegc_res_t;

  typedef enum logic [7:0] {
    AEGC_MODE_BCD = 8'h00,
    AEGC_MODE_ANG = 8'h01
  } aegc_mode_t;

  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] res;
  } aegc_cfg_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [15:0] wdata;
  } aegc_bus_t;
endpackage : aegc_pkg

//--- verilog/aegc_top.sv
// Two-port absolute Gray encoder position, compare and interrupt logic
//
// Contract
// - Two ports, Gray word converted to binary
// - Tracks changes up to 4 kHz rate
// - Resolution 8, 10 or 12 bits
// - BCD mode and 360 degree mode
// - Interrupt on target match or range hit
// - Origin offset makes any position zero
// - Lsb indicator follows encoder bit 0
// - Up indicator when value increased
// - Down indicator when value decreased
// - BCD present value updated per scan
// - Two words per port, low first
// - Host loads tables and starts compare
// - Start, stop compare, overwrite present value
// - Present value and status always readable
// - Global mask blocks every interrupt
// - Resolution and mode field encodings
// - Eight range flags per port
// - Error code none, hardware, configuration
`timescale 1ns/1ps
module aegc_top #(
  parameter int unsigned ANGLE_FULL = 360
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Register port
  input wire aegc_pkg::aegc_bus_t bus_req,
  output logic [15:0] rdata,
  // Encoder inputs and host scan
  input wire logic [aegc_pkg::AEGC_GW-1:0] port1_code,
  input wire logic [aegc_pkg::AEGC_GW-1:0] port2_code,
  input wire logic scan_tick,
  input wire logic hw_fault,
  // Indicators and interrupt
  output logic port1_lsb_indicator,
  output logic port2_lsb_indicator,
  output logic port1_up_indicator,
  output logic port2_up_indicator,
  output logic port1_down_indicator,
  output logic port2_down_indicator,
  output logic irq
);
  import aegc_pkg::*;

  function automatic logic [3:0] res_bits(input logic [7:0] r);
    case (r)
      AEGC_RES10: res_bits = 4'ha;
      AEGC_RES12: res_bits = 4'hc;
      default: res_bits = 4'h8;
    endcase
  endfunction : res_bits

  function automatic logic [11:0] res_mask(input logic [7:0] r);
    logic [12:0] one;
    one = 13'h0001 << res_bits(r);
    res_mask = 12'(one - 13'h0001);
  endfunction : res_mask

  function automatic logic [11:0] gray2bin(input logic [11:0] g);
    logic [11:0] b;
    b = 12'h000;
    b[11] = g[11];
    for (int i = 10; i >= 0; i--)
    begin
      b[i] = b[i+1] ^ g[i];
    end
    gray2bin = b;
  endfunction : gray2bin

  function automatic logic [15:0] bin2bcd(input logic [11:0] v);
    logic [27:0] s;
    s = {16'h0000, v};
    for (int i = 0; i < 12; i++)
    begin
      for (int d = 0; d < 4; d++)
      begin
        if (s[12+4*d +: 4] > 4'h4)
        begin
          s[12+4*d +: 4] = s[12+4*d +: 4] + 4'h3;
        end
      end
      s = s << 1;
    end
    bin2bcd = s[27:12];
  endfunction : bin2bcd

  function automatic logic cfg_bad(input aegc_cfg_t c);
    cfg_bad = (c.res > AEGC_RES12) || (c.mode > AEGC_MODE_ANG);
  endfunction : cfg_bad

  // Register state
  aegc_cfg_t cfg_q [2];
  logic [11:0] org_q [2];
  logic [11:0] tbl_lo_q [2][AEGC_NCMP];
  logic [11:0] tbl_hi_q [2][AEGC_NCMP];
  logic [4:0] ctrl_q;
  logic [1:0] stat_q;
  logic [1:0] stat_d;
  logic [1:0] mask_q;
  logic [7:0] err_q;
  logic [15:0] rdata_q;
  logic [15:0] pv_lo_q [2];
  logic [7:0] flg_q [2];
  logic [1:0] hit_q;
  logic [11:0] prev_q [2];
  logic [1:0] lsb_q;
  logic [1:0] up_q;
  logic [1:0] dn_q;

  // Per port datapath
  logic [11:0] code_w [2];
  logic [11:0] gin_w [2];
  logic [11:0] raw_w [2];
  logic [11:0] rel_w [2];
  logic [11:0] val_w [2];
  logic [7:0] flg_w [2];
  logic [1:0] hit_w;

  assign code_w[0] = port1_code;
  assign code_w[1] = port2_code;

  // Bus decode
  wire wr = bus_req.wr;
  wire rd = bus_req.rd;
  wire [7:0] addr = bus_req.addr;
  wire [15:0] wdata = bus_req.wdata;
  wire tbl_hit = (addr[7:6] == AEGC_TBL_TOP) && !addr[4];
  wire tbl_port = addr[5];
  wire [2:0] tbl_idx = addr[3:1];
  wire rd_stat = rd && (addr == AEGC_STAT);
  wire cmp_bit0 = ctrl_q[AEGC_C_CMP_EN];

  genvar p;
  generate
    for (p = 0; p < 2; p++)
    begin : g_port
      logic [3:0] bits;
      logic [20:0] prod;
      logic [11:0] ang;
      assign bits = res_bits(cfg_q[p].res);
      // Upper code bits beyond the resolution are ignored
      assign gin_w[p] = code_w[p] & res_mask(cfg_q[p].res);
      // Sampled every clock, far faster than the encoder count rate
      assign raw_w[p] = gray2bin(gin_w[p]);
      // Wraps modulo the selected range
      assign rel_w[p] = (raw_w[p] - org_q[p]) & res_mask(cfg_q[p].res);
      assign prod = 21'(rel_w[p]) * 21'(ANGLE_FULL);
      assign ang = 12'(prod >> bits);
      assign val_w[p] = (cfg_q[p].mode == AEGC_MODE_ANG) ? ang : rel_w[p];
      for (genvar i = 0; i < AEGC_NCMP; i++)
      begin : g_cmp
        assign flg_w[p][i] = ctrl_q[AEGC_C_RANGE+p]
          ? (val_w[p] >= tbl_lo_q[p][i] && val_w[p] <= tbl_hi_q[p][i])
          : (val_w[p] == tbl_lo_q[p][i]);
      end
      // Only an enabled comparison raises anything
      assign hit_w[p] = ctrl_q[AEGC_C_CMP_EN+p] && (|flg_w[p]);

      always_ff @(posedge core_clk or posedge rst)
      begin
        if (rst)
        begin
          pv_lo_q[p] <= 16'h0000;
          flg_q[p] <= 8'h00;
          prev_q[p] <= 12'h000;
          lsb_q[p] <= 1'b0;
          up_q[p] <= 1'b0;
          dn_q[p] <= 1'b0;
          hit_q[p] <= 1'b0;
        end
        else
        begin
          if (scan_tick)
          begin
            pv_lo_q[p] <= bin2bcd(val_w[p]);
          end
          flg_q[p] <= (ctrl_q[AEGC_C_CMP_EN+p] && ctrl_q[AEGC_C_RANGE+p]) ? flg_w[p] : 8'h00;
          prev_q[p] <= raw_w[p];
          lsb_q[p] <= code_w[p][0];
          up_q[p] <= raw_w[p] > prev_q[p];
          dn_q[p] <= raw_w[p] < prev_q[p];
          hit_q[p] <= hit_w[p];
        end
      end
    end
  endgenerate

  // Hit edges are events; the read clear loses to a new event
  wire [1:0] cmp_ev = hit_w & ~hit_q;
  assign stat_d = (stat_q & ~{2{rd_stat}}) | cmp_ev;

  // Software writes
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      cfg_q[0] <= AEGC_CFG_RST;
      cfg_q[1] <= AEGC_CFG_RST;
      org_q[0] <= AEGC_ORG_RST;
      org_q[1] <= AEGC_ORG_RST;
      ctrl_q <= AEGC_CTRL_RST;
      mask_q <= AEGC_MASK_RST;
      stat_q <= 2'b00;
      for (int q = 0; q < 2; q++)
      begin
        for (int i = 0; i < AEGC_NCMP; i++)
        begin
          tbl_lo_q[q][i] <= 12'h000;
          tbl_hi_q[q][i] <= 12'h000;
        end
      end
    end
    else
    begin
      stat_q <= stat_d;
      if (wr)
      begin
        case (addr)
          AEGC_CFG1: cfg_q[0] <= wdata;
          AEGC_CFG2: cfg_q[1] <= wdata;
          AEGC_ORG1: org_q[0] <= wdata[11:0];
          AEGC_ORG2: org_q[1] <= wdata[11:0];
          AEGC_PRE1: org_q[0] <= raw_w[0] - wdata[11:0];
          AEGC_PRE2: org_q[1] <= raw_w[1] - wdata[11:0];
          AEGC_CTRL:
          begin
            ctrl_q <= wdata[4:0];
            if (wdata[AEGC_C_CAPT])
            begin
              org_q[0] <= raw_w[0];
            end
            if (wdata[AEGC_C_CAPT+1])
            begin
              org_q[1] <= raw_w[1];
            end
          end
          AEGC_MASK: mask_q <= wdata[1:0];
          default:
          begin
            if (tbl_hit)
            begin
              // Loading while comparing is allowed; flags follow next cycle
              if (addr[0])
              begin
                tbl_hi_q[tbl_port][tbl_idx] <= wdata[11:0];
              end
              else
              begin
                tbl_lo_q[tbl_port][tbl_idx] <= wdata[11:0];
              end
            end
          end
        endcase
      end
    end
  end

  // Error code, hardware fault takes priority
  wire [7:0] err_d = hw_fault ? AEGC_ERR_HW
    : ((cfg_bad(cfg_q[0]) || cfg_bad(cfg_q[1])) ? AEGC_ERR_CFG : AEGC_ERR_NONE);

  // Read mux; unmapped addresses read zero
  logic [15:0] rmux;
  always_comb
  begin
    rmux = 16'h0000;
    case (addr)
      AEGC_PV1_LO: rmux = pv_lo_q[0];
      AEGC_PV1_HI: rmux = 16'h0000;
      AEGC_PV2_LO: rmux = pv_lo_q[1];
      AEGC_PV2_HI: rmux = 16'h0000;
      AEGC_CFG1: rmux = cfg_q[0];
      AEGC_CFG2: rmux = cfg_q[1];
      AEGC_ORG1: rmux = {4'h0, org_q[0]};
      AEGC_ORG2: rmux = {4'h0, org_q[1]};
      AEGC_CTRL: rmux = {11'h000, ctrl_q};
      AEGC_STAT: rmux = {14'h0000, stat_q};
      AEGC_MASK: rmux = {14'h0000, mask_q};
      AEGC_FLG1: rmux = {7'h00, ctrl_q[AEGC_C_CMP_EN], flg_q[0]};
      AEGC_FLG2: rmux = {7'h00, ctrl_q[AEGC_C_CMP_EN+1], flg_q[1]};
      AEGC_ERR: rmux = {8'h00, err_q};
      default:
      begin
        if (tbl_hit)
        begin
          rmux = {4'h0, addr[0] ? tbl_hi_q[tbl_port][tbl_idx] : tbl_lo_q[tbl_port][tbl_idx]};
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      rdata_q <= 16'h0000;
      err_q <= AEGC_ERR_NONE;
    end
    else
    begin
      rdata_q <= rd ? rmux : 16'h0000;
      err_q <= err_d;
    end
  end

  assign rdata = rdata_q;
  // Global mask wins over every source
  assign irq = (|(stat_q & mask_q)) && !ctrl_q[AEGC_C_GMASK];
  assign port1_lsb_indicator = lsb_q[0];
  assign port2_lsb_indicator = lsb_q[1];
  assign port1_up_indicator = up_q[0];
  assign port2_up_indicator = up_q[1];
  assign port1_down_indicator = dn_q[0];
  assign port2_down_indicator = dn_q[1];

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_gray_decode: assert property ((raw_w[0] ^ (raw_w[0] >> 1)) == gin_w[0])
    else $error("port 1 gray decode wrong");
  a_range_limit: assert property ((raw_w[1] & ~res_mask(cfg_q[1].res)) == 12'h000)
    else $error("port 2 value beyond resolution");
  a_lsb_follow: assert property (##1 port1_lsb_indicator == $past(port1_code[0]))
    else $error("lsb indicator not following bit 0");
  a_up_flag: assert property ((raw_w[0] > prev_q[0]) |=> port1_up_indicator)
    else $error("up indicator missing");
  a_down_flag: assert property ((raw_w[1] < prev_q[1]) |=> port2_down_indicator)
    else $error("down indicator missing");
  a_pv_hold: assert property (!scan_tick |=> $stable(pv_lo_q[0]))
    else $error("present value changed between scans");
  a_pv_read: assert property (rd && addr == AEGC_PV2_LO |=> rdata == $past(pv_lo_q[1]))
    else $error("present value read mismatch");
  a_irq_gmask: assert property (ctrl_q[AEGC_C_GMASK] |-> !irq)
    else $error("interrupt while globally masked");
  a_event_sticky: assert property (cmp_ev[0] |=> stat_q[0] ##1 (stat_q[0] || $past(rd_stat)))
    else $error("compare event not held");
  a_preset_load: assert property (wr && addr == AEGC_PRE1
    |=> rel_w[0] == ($past(wdata[11:0]) & res_mask(cfg_q[0].res))
    || $changed(raw_w[0]))
    else $error("present value overwrite failed");
  a_angle_span: assert property ((cfg_q[0].mode == AEGC_MODE_ANG) |-> val_w[0] < 12'(ANGLE_FULL))
    else $error("angle beyond full turn");
  a_err_cfg: assert property (cfg_bad(cfg_q[0]) && !hw_fault |=> err_q == AEGC_ERR_CFG)
    else $error("configuration error not reported");
  a_bcd_digit: assert property (pv_lo_q[0][3:0] <= 4'h9 && pv_lo_q[0][7:4] <= 4'h9)
    else $error("present value digit not decimal");

  c_target_hit: cover property (cmp_bit0 && !ctrl_q[AEGC_C_RANGE] ##1 stat_q[0]);
  c_range_flag: cover property (flg_q[1] != 8'h00);
  c_irq_rise: cover property (!irq ##1 irq);
  c_angle_mode: cover property (cfg_q[1].mode == AEGC_MODE_ANG && scan_tick);
endmodule : aegc_top
